// ---- hdl/supply_monitor_shutdown_control.sv ----
// Notes on behaviour
// - supply fault stops stages, keeps registers
// - supply state readable in status register
// - fault shuts stages even with line high
// - pair refuses switch-on during faults, off allowed
// - reset-level supply: stages off, line low
// - filtered undervoltage: stages off, line low
// - delayed pair runs on in undervoltage
// - undervoltage end: release line, outputs to ones
// - supply fault freezes diagnostics, bus stays usable
// - supply return above reset level resets everything
// - filtered overvoltage: stages off, line low
// - delayed pair runs on in overvoltage
// - latch bit holds overvoltage shutdown until cleared
// - latch off: line released after filter
// - overvoltage end sets outputs to ones
// - low line sets outputs to ones
// - line is sensed input and open drain
// - high threshold test pattern clears bits 5,7
// - low threshold test pattern clears bits 6,7
// - out-of-range filter 60 to 135 us
// - internal reset extended 180 to 360 us
// - delayed switching debounced 30 to 80 ms
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// hysteresis filter: state follows raw only after raw differs long enough
module level_filter
   import supply_pkg::*;
#(
   parameter int SET_CYC = 1,                    // cycles before the state rises
   parameter int CLR_CYC = 1                     // cycles before the state falls
)(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic soft_rst_i,                 // internal reset, clears state
   input  wire logic raw_i,
   output logic      state_o
);
   logic [CNT_W-1:0] cnt_reg;                    // time raw has differed
   logic [CNT_W-1:0] lim;                        // last count before switching

   assign lim = raw_i ? CNT_W'(SET_CYC - 1) : CNT_W'(CLR_CYC - 1);

   // counter restarts from zero whenever raw agrees with the state again
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= '0;
         state_o <= 1'b0;
      end
      else if (soft_rst_i || raw_i == state_o)
      begin
         cnt_reg <= '0;
         if (soft_rst_i)
            state_o <= 1'b0;
      end
      else if (cnt_reg == lim)
      begin
         cnt_reg <= '0;
         state_o <= raw_i;
      end
      else
         cnt_reg <= cnt_reg + 1'b1;
   end
endmodule : level_filter

////////////////////////////////////////////////////////////////////////////////
module supply_monitor_shutdown_control
   import supply_pkg::*;
#(
   parameter int POR_EXT  = POR_EXT_CYC,         // internal reset stretch
   parameter int OFF_DEL  = OFF_DEL_CYC,         // delayed switching debounce
   parameter int PAIR_DEL = PAIR_DEL_CYC         // delayed pair run-on time
)(
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic [supply_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [supply_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                       wr_i,
   input  wire logic                       rd_i,
   output logic      [supply_pkg::DATA_W-1:0] rdata_o,
   input  wire logic                       under_cmp_i,
   input  wire logic                       over_cmp_i,
   input  wire logic                       por_cmp_i,
   input  wire logic                       shutdown_line_i,
   output logic                            shutdown_line_o,
   output logic                            shutdown_line_oe_o,
   input  wire logic                       pair_reset_input_i,
   input  wire logic                       bus_monitor_fault_i,
   input  wire logic                       ext_reset_i,
   input  wire logic [supply_pkg::NCH-1:0] diag_fault_i,
   output logic      [supply_pkg::NCH-1:0] stage_on_o,
   output logic                            high_test_o,
   output logic                            low_test_o
);
   import supply_pkg::*;

   logic [SYNC_W-1:0] meta_reg;                  // first synchroniser stage
   logic [SYNC_W-1:0] sync_reg;                  // second stage, the only one read
   logic              under_s, over_s, por_s;    // synchronised comparators
   logic              line_low_s;                // line sensed low
   logic              pair_rst_s, busmon_s, ext_s;
   logic [NCH-1:0]    fault_s;                   // synchronised fault reports
   logic [CNT_W-1:0]  por_cnt_reg;               // reset stretch countdown
   logic              soft_rst;                  // internal power-on reset
   logic              uv_st, ov_st;              // filtered supply states
   logic              uv_st_d, ov_st_d;          // delayed copies for edges
   logic              ov_lat_reg;                // overvoltage latched
   logic              trig;                      // any reason to shut down
   logic              del_st;                    // debounced trig
   logic              pair_exp;                  // pair run-on expired
   logic              shut_now;                  // stages are to be off
   logic              leave_ev;                  // end of under or overvoltage
   logic              block_on;                  // pair may not switch on
   logic              freeze;                    // diagnostics frozen
   logic [CFG_W-1:0]  cfg_reg;                   // supply_monitor_config
   logic [NCH-1:0]    out_reg, out_next;         // output register, 1 = off
   logic [NCH-1:0]    diag_reg;                  // sticky fault entries
   logic [ST_W-1:0]   status;                    // supply_status_register view
   logic [1:0]        pair_del;                  // delayed pair configuration
   logic              wr_out, wr_cfg, wr_diag;   // decoded writes

   ////////////////////////////////////////////////////////////////////////////
   // two flip-flops on every asynchronous input
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         // the line bit idles high, so no false low line follows reset
         meta_reg <= {4'b0001, {(SYNC_W-4){1'b0}}};
         sync_reg <= {4'b0001, {(SYNC_W-4){1'b0}}};
      end
      else
      begin
         meta_reg <= {under_cmp_i, over_cmp_i, por_cmp_i, shutdown_line_i,
                      pair_reset_input_i, bus_monitor_fault_i, ext_reset_i,
                      diag_fault_i};
         sync_reg <= meta_reg;
      end
   end

   assign {under_s, over_s, por_s} = sync_reg[SYNC_W-1 -: 3];
   assign line_low_s = ~sync_reg[SYNC_W-4];
   assign {pair_rst_s, busmon_s, ext_s} = sync_reg[NCH+2 -: 3];
   assign fault_s = sync_reg[NCH-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // internal reset: held while below the reset level, then stretched
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         por_cnt_reg <= CNT_W'(POR_EXT);
      else if (por_s)
         por_cnt_reg <= CNT_W'(POR_EXT);
      else if (por_cnt_reg != '0)
         por_cnt_reg <= por_cnt_reg - 1'b1;
   end

   assign soft_rst = por_s | (por_cnt_reg != '0);

   ////////////////////////////////////////////////////////////////////////////
   // supply filters, the delayed switching debounce and the pair timer
   level_filter #(.SET_CYC(OFF_FILTER_CYC), .CLR_CYC(ON_FILTER_CYC)) uv_filt
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .soft_rst_i (soft_rst),
      .raw_i      (under_s),
      .state_o    (uv_st)
   );

   level_filter #(.SET_CYC(OFF_FILTER_CYC), .CLR_CYC(ON_FILTER_CYC)) ov_filt
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .soft_rst_i (soft_rst),
      .raw_i      (over_s),
      .state_o    (ov_st)
   );

   // a low line alone also shuts down, with or without our own drive
   assign trig = uv_st | ov_st | ov_lat_reg | line_low_s;

   level_filter #(.SET_CYC(OFF_DEL), .CLR_CYC(1)) del_filt
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .soft_rst_i (soft_rst),
      .raw_i      (trig),
      .state_o    (del_st)
   );

   level_filter #(.SET_CYC(PAIR_DEL), .CLR_CYC(1)) pair_filt
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .soft_rst_i (soft_rst),
      .raw_i      (trig),
      .state_o    (pair_exp)
   );

   // the impact setting picks immediate or debounced switch-off
   assign shut_now = cfg_reg[CFG_IMPACT] ? del_st : trig;
   assign leave_ev = (uv_st_d & ~uv_st) | (ov_st_d & ~ov_st);
   assign block_on = under_s | over_s | uv_st | ov_st | ov_lat_reg
                   | line_low_s | busmon_s | ext_s;
   assign freeze   = under_s | over_s | uv_st | ov_st;
   assign pair_del = {cfg_reg[CFG_PAIR_HI], cfg_reg[CFG_PAIR_LO]};

   assign wr_out  = wr_i && addr_i == ADDR_OUT;
   assign wr_cfg  = wr_i && addr_i == ADDR_CFG;
   assign wr_diag = wr_i && addr_i == ADDR_DIAG;

   ////////////////////////////////////////////////////////////////////////////
   // edge history of the supply states
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         uv_st_d <= 1'b0;
         ov_st_d <= 1'b0;
      end
      else
      begin
         uv_st_d <= uv_st;
         ov_st_d <= ov_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overvoltage latch: clear wins, cleared by the internal reset or while the latch bit is zero
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ov_lat_reg <= 1'b0;
      else if (soft_rst || !cfg_reg[CFG_LATCH])
         ov_lat_reg <= 1'b0;
      else if (ov_st)
         ov_lat_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration register; supply faults leave it untouched
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         cfg_reg <= CFG_RESET;
      else if (soft_rst)
         cfg_reg <= CFG_RESET;
      else if (wr_cfg)
         cfg_reg <= wdata_i[CFG_W-1:0];
   end

   // threshold test selects go to the analog comparators
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         high_test_o <= 1'b0;
         low_test_o  <= 1'b0;
      end
      else
      begin
         high_test_o <= !cfg_reg[CFG_NORMAL] && !cfg_reg[CFG_TEST_SEL];
         low_test_o  <= !cfg_reg[CFG_NORMAL] && cfg_reg[CFG_TEST_SEL];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output register next value: bus write, then every forcing cause
   always_comb
   begin
      out_next = out_reg;
      for (int i = 0; i < NCH; i++)
      begin
         if (wr_out)
         begin
            if (wdata_i[i])
               out_next[i] = 1'b1;               // switch-off always taken
            else if (!((i == PAIR_A || i == PAIR_B) && block_on))
               out_next[i] = 1'b0;
         end
         if (i == PAIR_A || i == PAIR_B)
         begin
            // delayed pair runs on until timer, its reset input or a write
            if (pair_del[i == PAIR_B])
            begin
               if ((trig && pair_exp) || pair_rst_s)
                  out_next[i] = 1'b1;
            end
            else if (shut_now || leave_ev || pair_rst_s)
               out_next[i] = 1'b1;
         end
         else if (shut_now || leave_ev)
            out_next[i] = 1'b1;
      end
   end

   // stages follow the register; a leaving edge sets the ones
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         out_reg <= OUT_RESET;
      else if (soft_rst)
         out_reg <= OUT_RESET;
      else
         out_reg <= out_next;
   end

   // stages are driven from a flop; the internal reset kills all at once
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         stage_on_o <= '0;
      else if (soft_rst)
         stage_on_o <= '0;
      else
         stage_on_o <= ~out_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // open-drain shutdown line: only ever pulled low
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         shutdown_line_o    <= 1'b0;
         shutdown_line_oe_o <= 1'b1;
      end
      else
      begin
         shutdown_line_o    <= 1'b0;
         shutdown_line_oe_o <= por_s | uv_st | ov_st | ov_lat_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // diagnostic entries: frozen during supply faults, write one to clear
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         diag_reg <= DIAG_RESET;
      else if (soft_rst)
         diag_reg <= DIAG_RESET;
      else
         diag_reg <= (diag_reg & ~(wr_diag ? wdata_i[NCH-1:0] : '0))
                   | (freeze ? '0 : fault_s);
   end

   // live supply state for software
   always_comb
   begin
      status           = '0;
      status[ST_LINE]  = ~line_low_s;
      status[ST_UV]    = uv_st;
      status[ST_OV]    = ov_st;
      status[ST_LATCH] = ov_lat_reg;
      status[ST_POR]   = soft_rst;
      status[ST_OV_OK] = ~over_s;
      status[ST_UV_OK] = ~under_s;
      status[ST_ALLOK] = ~over_s & ~under_s;
   end

   // read data stand for one cycle only; unmapped reads give zero
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_o <= '0;
      else if (rd_i)
      begin
         case (addr_i)
            ADDR_OUT:    rdata_o <= DATA_W'(out_reg);
            ADDR_CFG:    rdata_o <= DATA_W'(cfg_reg);
            ADDR_STATUS: rdata_o <= DATA_W'(status);
            ADDR_DIAG:   rdata_o <= DATA_W'(diag_reg);
            default:     rdata_o <= '0;
         endcase
      end
      else
         rdata_o <= '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence por_release_s;
      $fell(por_s) ##1 soft_rst [*8];
   endsequence

   sequence pair_on_refused_s;
      wr_out && !wdata_i[PAIR_A] && block_on && out_reg[PAIR_A];
   endsequence

   por_kills_stages_a: assert property (@(posedge clk_i) disable iff (rst_i)
      por_s |=> stage_on_o == '0 && shutdown_line_oe_o)
      else $error("stages on or line released under reset level");

   por_stretch_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(por_s) |-> por_release_s)
      else $error("internal reset ended too early");

   uv_line_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      uv_st |=> shutdown_line_oe_o)
      else $error("line not driven low in undervoltage");

   uv_stages_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      uv_st && !cfg_reg[CFG_IMPACT] |=> out_reg[13:0] == '1 && stage_on_o[13:0] == '0)
      else $error("stages left on in undervoltage");

   pair_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pair_on_refused_s |=> out_reg[PAIR_A])
      else $error("pair switched on during fault");

   latch_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ov_lat_reg && cfg_reg[CFG_LATCH] && !soft_rst && !wr_cfg |=> ov_lat_reg)
      else $error("overvoltage latch dropped");

   diag_frozen_a: assert property (@(posedge clk_i) disable iff (rst_i)
      freeze && !wr_diag && !soft_rst |=> diag_reg == $past(diag_reg))
      else $error("diagnostics changed while frozen");

   leave_ones_a: assert property (@(posedge clk_i) disable iff (rst_i)
      leave_ev && !soft_rst |=> out_reg[13:0] == '1 && out_reg[NCH-1:16] == '1)
      else $error("outputs not set to ones on supply return");

   line_low_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      line_low_s && !cfg_reg[CFG_IMPACT] |=> out_reg[0] && out_reg[NCH-1])
      else $error("low line did not switch stages off");

   uv_rise_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(uv_st) |-> $past(under_s, 1) && $past(under_s, 2))
      else $error("undervoltage state without lasting cause");

   test_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_cfg && !soft_rst && wdata_i[2:1] == 2'b00 |=> ##1 high_test_o && !low_test_o)
      else $error("high threshold test not selected");
endmodule : supply_monitor_shutdown_control

// ---- shared/supply_pkg.sv ----
package supply_pkg;
   // bus geometry
   localparam int ADDR_W = 8;                    // byte address width
   localparam int DATA_W = 32;                   // bus data width
   localparam int NCH    = 18;                   // number of output stages
   localparam int CNT_W  = 24;                   // width of every timer
   localparam int CFG_W  = 8;                    // supply monitor config width
   localparam int ST_W   = 8;                    // supply status width

   // register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_OUT    = 8'h00; // output register, 1 = stage off
   localparam logic [ADDR_W-1:0] ADDR_CFG    = 8'h04; // supply_monitor_config
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08; // supply_status_register
   localparam logic [ADDR_W-1:0] ADDR_DIAG   = 8'h0c; // diagnostic fault entries

   // supply_monitor_config fields
   localparam int CFG_TEST_SEL = 1;              // 0: high threshold test, 1: low threshold test
   localparam int CFG_NORMAL   = 2;              // 0: threshold test active
   localparam int CFG_IMPACT   = 3;              // shutdown_impact_select, 1 = delayed switching
   localparam int CFG_LATCH    = 4;              // overvoltage_latch_select
   localparam int CFG_PAIR_LO  = 5;              // pair_delay_config, channel 15
   localparam int CFG_PAIR_HI  = 6;              // pair_delay_config, channel 16
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h04; // thresholds normal, all else off

   // supply_status_register fields
   localparam int ST_LINE  = 0;                  // sensed shutdown line level
   localparam int ST_UV    = 1;                  // filtered undervoltage state
   localparam int ST_OV    = 2;                  // filtered overvoltage state
   localparam int ST_LATCH = 3;                  // overvoltage latched
   localparam int ST_POR   = 4;                  // internal reset running
   localparam int ST_OV_OK = 5;                  // supply below high threshold
   localparam int ST_UV_OK = 6;                  // supply above low threshold
   localparam int ST_ALLOK = 7;                  // supply inside the window

   // channel positions of the delayed pair (channels 15 and 16)
   localparam int PAIR_A = 14;
   localparam int PAIR_B = 15;

   // reset values
   localparam logic [NCH-1:0] OUT_RESET  = 18'h3ffff; // every stage off
   localparam logic [NCH-1:0] DIAG_RESET = 18'h00000;

   // timing, figures in ns, counts derived from the clock period
   localparam int CLK_NS        = 40;
   localparam int OFF_FILTER_NS = 60000;         // off_filter_time, least value
   localparam int ON_FILTER_NS  = 60000;         // on_filter_time
   localparam int POR_EXT_NS    = 180000;        // reset extension, least value
   localparam int OFF_DEL_NS    = 30000000;      // delayed switching debounce, least value
   localparam int PAIR_DEL_NS   = 50000000;      // pair_delay_time
   localparam int OFF_FILTER_CYC = (OFF_FILTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int ON_FILTER_CYC  = (ON_FILTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int POR_EXT_CYC    = (POR_EXT_NS + CLK_NS - 1) / CLK_NS;
   localparam int OFF_DEL_CYC    = (OFF_DEL_NS + CLK_NS - 1) / CLK_NS;
   localparam int PAIR_DEL_CYC   = (PAIR_DEL_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_W         = 7 + NCH;      // synchronised input bundle
endpackage : supply_pkg

// ---- tb/supply_env.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// supply side of the block: comparators and the shared open drain line
module supply_env (
   input  wire logic vdd_under_i,                // supply below low threshold
   input  wire logic vdd_over_i,                 // supply above high threshold
   input  wire logic vdd_por_i,                  // supply below reset threshold
   input  wire logic high_test_i,                // high threshold lowered
   input  wire logic low_test_i,                 // low threshold raised
   input  wire logic oe_i,                       // device pulls the line low
   input  wire logic ext_pull_i,                 // another party pulls it low
   input  wire logic data_i,                     // open drain data, low pulls
   output logic      under_cmp_o,
   output logic      over_cmp_o,
   output logic      por_cmp_o,
   output logic      line_o
);
   // a nominal 5 V supply trips a test threshold at once
   assign over_cmp_o  = vdd_over_i | high_test_i;
   assign under_cmp_o = vdd_under_i | low_test_i;
   assign por_cmp_o   = vdd_por_i;
   // wired and with a pull-up, so a released line reads high
   assign line_o      = ~((oe_i & ~data_i) | ext_pull_i);
endmodule : supply_env

// ---- tb/supply_monitor_shutdown_control_tb.sv ----
`timescale 1ns/10ps

module supply_monitor_shutdown_control_tb;
   import supply_pkg::*;
   localparam int PEXT = 10;                     // short reset stretch
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = 8'h00;
   logic [DATA_W-1:0] wdata_i = 32'h0;
   logic              wr_i = 1'b0;
   logic              rd_i = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic              under = 1'b0;              // supply states set by the tests
   logic              over = 1'b0;
   logic              por = 1'b0;
   logic              ext = 1'b0;                // external pull on the line
   logic              prst = 1'b0;               // pair reset input
   logic [NCH-1:0]    flt = '0;                  // per-channel fault reports
   logic              ucmp, ocmp, pcmp, line, oe, htest, ltest, ldat;
   logic [NCH-1:0]    stage_on_o;
   logic [DATA_W-1:0] rv;                        // last read data
   int                failures = 0;
   int                tests_run = 0;

   always #20 clk_i = ~clk_i;

   supply_env env (.vdd_under_i(under), .vdd_over_i(over), .vdd_por_i(por),
      .high_test_i(htest), .low_test_i(ltest), .oe_i(oe), .ext_pull_i(ext), .data_i(ldat),
      .under_cmp_o(ucmp), .over_cmp_o(ocmp), .por_cmp_o(pcmp), .line_o(line));

   supply_monitor_shutdown_control #(.POR_EXT(PEXT), .OFF_DEL(20), .PAIR_DEL(30)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .under_cmp_i(ucmp), .over_cmp_i(ocmp),
      .por_cmp_i(pcmp), .shutdown_line_i(line), .shutdown_line_o(ldat),
      .shutdown_line_oe_o(oe), .pair_reset_input_i(prst), .bus_monitor_fault_i(1'b0),
      .ext_reset_i(1'b0), .diag_fault_i(flt), .stage_on_o(stage_on_o),
      .high_test_o(htest), .low_test_o(ltest));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle

   // one write cycle, ends on the edge that drops the strobe
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // read data stand only in the cycle after the strobe, so sample mid-cycle
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      @(negedge clk_i);
      chk(rdata_o, exp);
   endtask : rchk

   // stage and line drive, settled at the falling edge; ends on a rising edge
   task automatic pins(input logic [NCH-1:0] es, input logic eo);
      @(negedge clk_i);
      chk({14'h0, stage_on_o}, {14'h0, es});
      chk({31'h0, oe}, {31'h0, eo});
      @(posedge clk_i);
   endtask : pins

   task automatic done(input string name);
      $display("test %s finished, %0d failures so far", name, failures);
   endtask : done

   task automatic end_of_test;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      idle(16);
      rst_i <= 1'b0;
      idle(PEXT + 4);
      rchk(ADDR_OUT, 32'h3ffff);
      rchk(ADDR_CFG, 32'h4);
      rchk(ADDR_STATUS, 32'he1);
      rchk(8'h10, 32'h0);
      done("reset");
      wr(ADDR_OUT, 32'h3fffe);
      pins(18'h1, 1'b0);
      under <= 1'b1;
      idle(10);
      wr(ADDR_OUT, 32'h3bffe);
      rchk(ADDR_OUT, 32'h3fffe);
      pins(18'h1, 1'b0);
      idle(1500);
      pins(18'h0, 1'b1);
      rchk(ADDR_STATUS, 32'h22);
      wr(ADDR_CFG, 32'h24);
      flt <= 18'h8;
      rchk(ADDR_CFG, 32'h24);
      rchk(ADDR_DIAG, 32'h0);
      wr(ADDR_CFG, 32'h4);
      under <= 1'b0;
      idle(1510);
      pins(18'h0, 1'b0);
      flt <= 18'h0;
      rchk(ADDR_OUT, 32'h3ffff);
      rchk(ADDR_DIAG, 32'h8);
      wr(ADDR_DIAG, 32'h8);
      rchk(ADDR_DIAG, 32'h0);
      done("undervoltage");
      // two bursts that together outlast the filter, each too short alone
      wr(ADDR_OUT, 32'h3fffe);
      under <= 1'b1;
      idle(1000);
      under <= 1'b0;
      idle(4);
      under <= 1'b1;
      idle(1000);
      under <= 1'b0;
      pins(18'h1, 1'b0);
      ext <= 1'b1;
      idle(6);
      pins(18'h0, 1'b0);
      rchk(ADDR_OUT, 32'h3ffff);
      idle(1);
      ext <= 1'b0;
      // delayed pair runs on under a low line until its timer ends
      wr(ADDR_CFG, 32'h24);
      wr(ADDR_OUT, 32'h3bffe);
      ext <= 1'b1;
      idle(6);
      pins(18'h4000, 1'b0);
      idle(30);
      pins(18'h0, 1'b0);
      ext <= 1'b0;
      idle(4);
      wr(ADDR_OUT, 32'h3bfff);
      pins(18'h4000, 1'b0);
      prst <= 1'b1;
      idle(4);
      pins(18'h0, 1'b0);
      prst <= 1'b0;
      done("glitch and line");
      wr(ADDR_CFG, 32'h14);
      over <= 1'b1;
      idle(1510);
      pins(18'h0, 1'b1);
      over <= 1'b0;
      idle(1510);
      pins(18'h0, 1'b1);
      wr(ADDR_CFG, 32'h4);
      idle(6);
      pins(18'h0, 1'b0);
      rchk(ADDR_OUT, 32'h3ffff);
      done("overvoltage latch");
      for (int i = 0; i < 2; i++)
      begin
         wr(ADDR_CFG, i ? 32'h2 : 32'h0);
         idle(6);
         rchk(ADDR_STATUS, i ? 32'h21 : 32'h41);
         wr(ADDR_CFG, 32'h4);
         idle(6);
         rchk(ADDR_STATUS, 32'he1);
      end
      done("threshold test");
      wr(ADDR_OUT, 32'h3fffe);
      wr(ADDR_CFG, 32'h0c);
      por <= 1'b1;
      idle(4);
      pins(18'h0, 1'b1);
      por <= 1'b0;
      idle(PEXT + 6);
      rchk(ADDR_OUT, 32'h3ffff);
      rchk(ADDR_CFG, 32'h4);
      done("power on reset");
      end_of_test();
   end

   // the tests take some 8300 cycles; a hang is cut off well beyond that
   initial
   begin
      idle(20000);
      failures++;
      $display("watchdog expired at %0t", $time);
      end_of_test();
   end
endmodule : supply_monitor_shutdown_control_tb
